// ### core/spi_eeprom_pkg.sv
// Shared constants and types of the serial EEPROM command and protection block.
`default_nettype none
package spi_eeprom_pkg;
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned HI_W       = ADDR_W - 8;
  localparam int unsigned PAGE_W     = 5;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned MEM_BYTES  = 1024;
  localparam logic [7:0]  MEM_RESET  = 8'hFF;

  localparam logic [7:0] OP_MASK      = 8'hF7;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_ARRAY_RD  = 8'h03;
  localparam logic [7:0] OP_ARRAY_WR  = 8'h02;

  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_LATCH_BIT = 1;
  localparam int unsigned STAT_BP_LO_BIT = 2;
  localparam int unsigned STAT_BP_HI_BIT = 3;
  localparam int unsigned STAT_PIN_PROTECT_ENABLE_BIT  = 7;
  localparam logic [7:0]  STAT_BUSY_VAL  = 8'hFF;
  localparam logic [1:0]  BP_RESET       = 2'h0;
  localparam logic        PIN_PROTECT_ENABLE_RESET     = 1'b0;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned WRITE_CYCLE_MS = 5;
  localparam int unsigned WRITE_CYCLE_COUNT = (WRITE_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    L_OPC    = 3'h0,
    L_ADRH   = 3'h1,
    L_ADRL   = 3'h3,
    L_WDATA  = 3'h2,
    L_RDOUT  = 3'h6,
    L_STOUT  = 3'h7,
    L_SWDATA = 3'h5,
    L_IGNORE = 3'h4
  } link_state_t;

  typedef enum logic [1:0] {
    PEND_NONE   = 2'h0,
    PEND_ARRAY  = 2'h1,
    PEND_STATUS = 2'h2
  } pend_kind_t;

  typedef enum logic [1:0] {
    PROG_IDLE = 2'h0,
    PROG_RUN  = 2'h1
  } prog_state_t;

  typedef struct packed {
    logic       busy;
    logic       latch;
    logic       pin_protect_enable;
    logic [1:0] guard;
  } dev_status_t;
endpackage
`default_nettype wire

// ### core/spi_eeprom_command_protect.sv
// Serial EEPROM command interpreter, page write engine and write protection.
`default_nettype none
module spi_eeprom_command_protect #(
  parameter int unsigned WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_COUNT
) (
  // System clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Serial link
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic si,
  input  wire logic holdN,
  output var  logic so,
  output var  logic soOe,
  // Protection pin
  input  wire logic wpN
);

  logic                linkRstN;
  logic                oeDrive_r;
  spi_eeprom_pkg::link_state_t linkState_r;
  spi_eeprom_pkg::link_state_t linkState_nxt;
  logic [2:0]          bitIdx_r;
  logic [7:0]          shift_r;
  logic [7:0]          shiftNxt;
  logic                byteDone;
  logic [7:0]          opc;
  logic                rdMode_r;
  logic [spi_eeprom_pkg::HI_W-1:0]   addrHi_r;
  logic [spi_eeprom_pkg::ADDR_W-1:0] fullAddr;
  logic [spi_eeprom_pkg::ADDR_W-1:0] rdAddr_r;
  logic [7:0]          outByte_r;
  logic [7:0]          statusByte;
  spi_eeprom_pkg::dev_status_t stSrc;
  spi_eeprom_pkg::dev_status_t stLink1_r;
  spi_eeprom_pkg::dev_status_t stLink2_r;
  spi_eeprom_pkg::pend_kind_t  pendKind_r;
  logic                commitOk_r;
  logic [7:0]          pageBuf_r [spi_eeprom_pkg::PAGE_BYTES];
  logic [spi_eeprom_pkg::PAGE_BYTES-1:0] pageMask_r;
  logic [spi_eeprom_pkg::ADDR_W-spi_eeprom_pkg::PAGE_W-1:0] wrBase_r;
  logic [spi_eeprom_pkg::PAGE_W-1:0] wrPtr_r;
  logic [7:0]          statBuf_r;
  logic                setTgl_r;
  logic                clrTgl_r;
  logic                cmdSet;
  logic                cmdClr;
  logic                cmdStRd;
  logic                cmdStWr;
  logic                cmdRd;
  logic                cmdWr;
  logic                linkBusy;

  logic [2:0]          csSync_r;
  logic [1:0]          wpSync_r;
  logic [2:0]          setSync_r;
  logic [2:0]          clrSync_r;
  spi_eeprom_pkg::pend_kind_t kindSync1_r;
  spi_eeprom_pkg::pend_kind_t kindSync2_r;
  logic [1:0]          okSync_r;
  logic                csRise;
  logic                setEvent;
  logic                clrEvent;
  logic                hwProt;
  spi_eeprom_pkg::prog_state_t progState_r;
  logic [31:0]         cycCnt_r;
  logic [spi_eeprom_pkg::PAGE_W:0] progIdx_r;
  logic                progStatus_r;
  logic                cycDone;
  logic                latch_r;
  logic [1:0]          guard_r;
  logic                pin_protect_enable_r;
  logic                memWe;
  logic [spi_eeprom_pkg::ADDR_W-1:0] memAddr;
  logic [7:0]          mem [spi_eeprom_pkg::MEM_BYTES];

  function automatic logic guarded(input logic [1:0] g, input logic [spi_eeprom_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (g)
      2'h1:    hit = (a[spi_eeprom_pkg::ADDR_W-1:spi_eeprom_pkg::ADDR_W-2] == 2'h3);
      2'h2:    hit = a[spi_eeprom_pkg::ADDR_W-1];
      2'h3:    hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Frame logic is reset whenever select is high, so every select fall starts a new frame.
  assign linkRstN = rst_n & ~csN;
  // Pausing floats the output at once and drives it again on resume, so the bit that stood
  // before the pause is back on the pin in time for the next rising edge.
  assign soOe     = oeDrive_r & holdN;

  assign shiftNxt = {shift_r[6:0], si};
  assign byteDone = (bitIdx_r == 3'h7);
  assign opc      = shiftNxt & spi_eeprom_pkg::OP_MASK;
  assign cmdSet   = (opc == spi_eeprom_pkg::OP_SET_LATCH);
  assign cmdClr   = (opc == spi_eeprom_pkg::OP_CLR_LATCH);
  assign cmdStRd  = (opc == spi_eeprom_pkg::OP_STAT_RD);
  assign cmdStWr  = (opc == spi_eeprom_pkg::OP_STAT_WR);
  assign cmdRd    = (opc == spi_eeprom_pkg::OP_ARRAY_RD);
  assign cmdWr    = (opc == spi_eeprom_pkg::OP_ARRAY_WR);
  assign linkBusy = stLink2_r.busy;
  assign fullAddr = {addrHi_r, shiftNxt};

  always_comb
  begin
    statusByte = 8'h00;
    statusByte[spi_eeprom_pkg::STAT_BUSY_BIT]  = stLink2_r.busy;
    statusByte[spi_eeprom_pkg::STAT_LATCH_BIT] = stLink2_r.latch;
    statusByte[spi_eeprom_pkg::STAT_BP_LO_BIT] = stLink2_r.guard[0];
    statusByte[spi_eeprom_pkg::STAT_BP_HI_BIT] = stLink2_r.guard[1];
    statusByte[spi_eeprom_pkg::STAT_PIN_PROTECT_ENABLE_BIT]  = stLink2_r.pin_protect_enable;
    if (stLink2_r.busy)
    begin
      statusByte = spi_eeprom_pkg::STAT_BUSY_VAL;
    end
  end

  always_comb
  begin
    linkState_nxt = linkState_r;
    case (linkState_r)
      spi_eeprom_pkg::L_OPC:
      begin
        if (byteDone)
        begin
          if (linkBusy && !cmdStRd)
            linkState_nxt = spi_eeprom_pkg::L_IGNORE;
          else if (cmdStRd)
            linkState_nxt = spi_eeprom_pkg::L_STOUT;
          else if (cmdStWr)
            linkState_nxt = spi_eeprom_pkg::L_SWDATA;
          else if (cmdRd || cmdWr)
            linkState_nxt = spi_eeprom_pkg::L_ADRH;
          else
            linkState_nxt = spi_eeprom_pkg::L_IGNORE;
        end
      end
      spi_eeprom_pkg::L_ADRH:
        if (byteDone) linkState_nxt = spi_eeprom_pkg::L_ADRL;
      spi_eeprom_pkg::L_ADRL:
        if (byteDone) linkState_nxt = rdMode_r ? spi_eeprom_pkg::L_RDOUT : spi_eeprom_pkg::L_WDATA;
      spi_eeprom_pkg::L_SWDATA:
        if (byteDone) linkState_nxt = spi_eeprom_pkg::L_IGNORE;
      spi_eeprom_pkg::L_WDATA,
      spi_eeprom_pkg::L_RDOUT,
      spi_eeprom_pkg::L_STOUT,
      spi_eeprom_pkg::L_IGNORE:
        linkState_nxt = linkState_r;
      default:
        linkState_nxt = spi_eeprom_pkg::L_IGNORE;
    endcase
  end

  // Frame sequencing on the link clock.
  always_ff @(posedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      linkState_r <= spi_eeprom_pkg::L_OPC;
      bitIdx_r    <= 3'h0;
      shift_r     <= 8'h00;
      rdMode_r    <= 1'b0;
      addrHi_r    <= '0;
      rdAddr_r    <= '0;
      outByte_r   <= 8'h00;
    end
    else if (holdN)
    begin
      bitIdx_r    <= bitIdx_r + 3'h1;
      shift_r     <= shiftNxt;
      linkState_r <= linkState_nxt;
      case (linkState_r)
        spi_eeprom_pkg::L_OPC:
        begin
          if (byteDone)
          begin
            rdMode_r  <= cmdRd;
            outByte_r <= statusByte;
          end
        end
        spi_eeprom_pkg::L_ADRH:
          if (byteDone) addrHi_r <= shiftNxt[spi_eeprom_pkg::HI_W-1:0];
        spi_eeprom_pkg::L_ADRL:
        begin
          if (byteDone && rdMode_r)
          begin
            // The array is only rewritten while busy, when reads are refused, so it is static here.
            outByte_r <= mem[fullAddr];
            rdAddr_r  <= fullAddr + 1'b1;
          end
        end
        spi_eeprom_pkg::L_RDOUT:
        begin
          if (byteDone)
          begin
            outByte_r <= mem[rdAddr_r];
            rdAddr_r  <= rdAddr_r + 1'b1;
          end
          else
            outByte_r <= {outByte_r[6:0], 1'b0};
        end
        spi_eeprom_pkg::L_STOUT:
          outByte_r <= byteDone ? statusByte : {outByte_r[6:0], 1'b0};
        default:
          outByte_r <= outByte_r;
      endcase
    end
  end

  // Command results that must outlive the frame; the system side acts on latch toggles once synchronised, on the rest after select rises.
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendKind_r <= spi_eeprom_pkg::PEND_NONE;
      commitOk_r <= 1'b0;
      pageMask_r <= '0;
      wrBase_r   <= '0;
      wrPtr_r    <= '0;
      statBuf_r  <= 8'h00;
      setTgl_r   <= 1'b0;
      clrTgl_r   <= 1'b0;
    end
    else if (!csN && holdN)
    begin
      commitOk_r <= 1'b0;
      if (linkState_r == spi_eeprom_pkg::L_OPC && bitIdx_r == 3'h0)
        pendKind_r <= spi_eeprom_pkg::PEND_NONE;
      if (linkState_r == spi_eeprom_pkg::L_OPC && byteDone && !linkBusy)
      begin
        if (cmdSet) setTgl_r <= ~setTgl_r;
        if (cmdClr) clrTgl_r <= ~clrTgl_r;
        if (cmdWr) pendKind_r <= spi_eeprom_pkg::PEND_ARRAY;
        if (cmdStWr) pendKind_r <= spi_eeprom_pkg::PEND_STATUS;
      end
      if (linkState_r == spi_eeprom_pkg::L_ADRL && byteDone && !rdMode_r)
      begin
        wrBase_r   <= fullAddr[spi_eeprom_pkg::ADDR_W-1:spi_eeprom_pkg::PAGE_W];
        wrPtr_r    <= fullAddr[spi_eeprom_pkg::PAGE_W-1:0];
        pageMask_r <= '0;
      end
      if (linkState_r == spi_eeprom_pkg::L_WDATA && byteDone)
      begin
        pageMask_r[wrPtr_r] <= 1'b1;
        wrPtr_r    <= wrPtr_r + 1'b1;
        commitOk_r <= 1'b1;
      end
      if (linkState_r == spi_eeprom_pkg::L_SWDATA && byteDone)
      begin
        statBuf_r  <= shiftNxt;
        commitOk_r <= 1'b1;
      end
    end
  end

  generate
    for (genvar i = 0; i < spi_eeprom_pkg::PAGE_BYTES; i++)
    begin : g_page
      always_ff @(posedge sck or negedge rst_n)
      begin
        if (!rst_n)
          pageBuf_r[i] <= 8'h00;
        else if (!csN && holdN && linkState_r == spi_eeprom_pkg::L_WDATA && byteDone
                 && wrPtr_r == (spi_eeprom_pkg::PAGE_W)'(i))
          pageBuf_r[i] <= shiftNxt;
      end
    end
  endgenerate

  // Status bits reach the link clock through two flops; they can change mid-frame when a write cycle ends.
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stLink1_r <= '0;
      stLink2_r <= '0;
    end
    else
    begin
      stLink1_r <= stSrc;
      stLink2_r <= stLink1_r;
    end
  end

  // Serial output changes on the falling edge; a pause leaves the standing bit untouched.
  always_ff @(negedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      so        <= 1'b0;
      oeDrive_r <= 1'b0;
    end
    else
    begin
      so        <= outByte_r[7];
      oeDrive_r <= (linkState_r == spi_eeprom_pkg::L_RDOUT) || (linkState_r == spi_eeprom_pkg::L_STOUT);
    end
  end

  // System side: synchronisers.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csSync_r    <= 3'h7;
      wpSync_r    <= 2'h3;
      setSync_r   <= 3'h0;
      clrSync_r   <= 3'h0;
      kindSync1_r <= spi_eeprom_pkg::PEND_NONE;
      kindSync2_r <= spi_eeprom_pkg::PEND_NONE;
      okSync_r    <= 2'h0;
    end
    else
    begin
      csSync_r    <= {csSync_r[1:0], csN};
      wpSync_r    <= {wpSync_r[0], wpN};
      setSync_r   <= {setSync_r[1:0], setTgl_r};
      clrSync_r   <= {clrSync_r[1:0], clrTgl_r};
      kindSync1_r <= pendKind_r;
      kindSync2_r <= kindSync1_r;
      okSync_r    <= {okSync_r[0], commitOk_r};
    end
  end

  assign csRise   = csSync_r[1] & ~csSync_r[2];
  assign setEvent = setSync_r[1] ^ setSync_r[2];
  assign clrEvent = clrSync_r[1] ^ clrSync_r[2];
  assign hwProt   = pin_protect_enable_r & ~wpSync_r[1];
  assign cycDone  = (progState_r == spi_eeprom_pkg::PROG_RUN) && (cycCnt_r == 32'(WRITE_CYCLES - 1));
  assign stSrc    = '{busy: (progState_r == spi_eeprom_pkg::PROG_RUN), latch: latch_r, pin_protect_enable: pin_protect_enable_r, guard: guard_r};

  // Self-timed write cycle; page bytes are committed one per clock at its start.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      progState_r  <= spi_eeprom_pkg::PROG_IDLE;
      cycCnt_r     <= 32'h0;
      progIdx_r    <= '0;
      progStatus_r <= 1'b0;
    end
    else
    begin
      case (progState_r)
        spi_eeprom_pkg::PROG_IDLE:
        begin
          cycCnt_r  <= 32'h0;
          progIdx_r <= '0;
          if (csRise && okSync_r[1] && latch_r)
          begin
            if (kindSync2_r == spi_eeprom_pkg::PEND_ARRAY)
            begin
              progState_r  <= spi_eeprom_pkg::PROG_RUN;
              progStatus_r <= 1'b0;
            end
            else if (kindSync2_r == spi_eeprom_pkg::PEND_STATUS && !hwProt)
            begin
              progState_r  <= spi_eeprom_pkg::PROG_RUN;
              progStatus_r <= 1'b1;
            end
          end
        end
        spi_eeprom_pkg::PROG_RUN:
        begin
          cycCnt_r <= cycCnt_r + 32'h1;
          if (!progIdx_r[spi_eeprom_pkg::PAGE_W])
            progIdx_r <= progIdx_r + 1'b1;
          if (cycDone)
            progState_r <= spi_eeprom_pkg::PROG_IDLE;
        end
        default:
          progState_r <= spi_eeprom_pkg::PROG_IDLE;
      endcase
    end
  end

  assign memAddr = {wrBase_r, progIdx_r[spi_eeprom_pkg::PAGE_W-1:0]};
  assign memWe   = (progState_r == spi_eeprom_pkg::PROG_RUN) && !progStatus_r
                   && !progIdx_r[spi_eeprom_pkg::PAGE_W] && pageMask_r[progIdx_r[spi_eeprom_pkg::PAGE_W-1:0]]
                   && !guarded(guard_r, memAddr);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < spi_eeprom_pkg::MEM_BYTES; i++)
        mem[i] <= spi_eeprom_pkg::MEM_RESET;
    end
    else if (memWe)
      mem[memAddr] <= pageBuf_r[progIdx_r[spi_eeprom_pkg::PAGE_W-1:0]];
  end

  // Write latch; a set arriving with a clear in the same cycle wins unless a write cycle is running, when the clear wins.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      latch_r <= 1'b0;
    else if (setEvent && progState_r == spi_eeprom_pkg::PROG_IDLE)
      latch_r <= 1'b1;
    else if (clrEvent || cycDone)
      latch_r <= 1'b0;
  end

  // Protection bits stand in for nonvolatile cells and change only when a cycle ends.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      guard_r <= spi_eeprom_pkg::BP_RESET;
      pin_protect_enable_r  <= spi_eeprom_pkg::PIN_PROTECT_ENABLE_RESET;
    end
    else if (cycDone && progStatus_r)
    begin
      guard_r <= {statBuf_r[spi_eeprom_pkg::STAT_BP_HI_BIT], statBuf_r[spi_eeprom_pkg::STAT_BP_LO_BIT]};
      pin_protect_enable_r  <= statBuf_r[spi_eeprom_pkg::STAT_PIN_PROTECT_ENABLE_BIT];
    end
  end

endmodule
`default_nettype wire

// ### tb/spi_host_model.sv
// SPI mode 0 host model that frames transfers and runs its clock only inside frames.
`default_nettype none
module spi_host_model (
  // Serial link
  output var  logic sck,
  output var  logic csN,
  output var  logic si,
  output var  logic holdN,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_NS = 24;

  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    holdN = 1'b1;
  end

  task automatic start();
    #7;
    csN = 1'b0;
    #HALF_NS;
  endtask

  // The clock idles low, so data is set up in the low phase and read back at the rise.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      si = tx[b];
      #HALF_NS;
      sck = 1'b1;
      rx[b] = so;
      #HALF_NS;
      sck = 1'b0;
    end
  endtask

  // Select rises in the low phase right after the last bit; the released data line is inverted.
  task automatic stop();
    #10;
    csN = 1'b1;
    si = ~si;
    #100;
  endtask

  task automatic pause();
    #5;
    holdN = 1'b0;
    #100;
    holdN = 1'b1;
    #5;
  endtask
endmodule
`default_nettype wire

// ### tb/spi_eeprom_command_protect_asserts.sv
// Port-level checker for the serial EEPROM command and protection block.
`default_nettype none
module spi_eeprom_command_protect_asserts #(
  parameter int unsigned WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_COUNT
) (
  // System clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Serial link
  input  wire logic sck,
  input  wire logic csN,
  input  wire logic si,
  input  wire logic holdN,
  input  wire logic so,
  input  wire logic soOe,
  // Protection pin
  input  wire logic wpN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] bitCnt_r;
  logic [7:0] opc_r;
  logic [7:0] opM;
  logic       isWrOp;
  logic       isKnown;

  // The count saturates so that long reads never wrap back into the opcode window.
  always_ff @(posedge sck or posedge csN or negedge rst_n)
  begin
    if (!rst_n || csN)
    begin
      bitCnt_r <= 7'h00;
      opc_r <= 8'h00;
    end
    else if (holdN)
    begin
      if (bitCnt_r < 7'h08)
        opc_r <= {opc_r[6:0], si};
      if (bitCnt_r != 7'h7F)
        bitCnt_r <= bitCnt_r + 7'h01;
    end
  end

  assign opM = opc_r & spi_eeprom_pkg::OP_MASK;
  assign isWrOp = opM == spi_eeprom_pkg::OP_ARRAY_WR || opM == spi_eeprom_pkg::OP_STAT_WR
    || opM == spi_eeprom_pkg::OP_SET_LATCH || opM == spi_eeprom_pkg::OP_CLR_LATCH;
  assign isKnown = isWrOp || opM == spi_eeprom_pkg::OP_STAT_RD || opM == spi_eeprom_pkg::OP_ARRAY_RD;

  sequence s_opcode_open;
    bitCnt_r < 7'h08;
  endsequence
  sequence s_stat_ready;
    bitCnt_r == 7'h08 && opM == spi_eeprom_pkg::OP_STAT_RD && holdN;
  endsequence
  sequence s_addr_open;
    bitCnt_r < 7'h18 && opM == spi_eeprom_pkg::OP_ARRAY_RD;
  endsequence

  chk_oe_deselect: assert property (@(posedge sys_clk) disable iff (!rst_n) csN |-> !soOe)
    else $error("output enabled while deselected");
  chk_oe_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) !holdN |-> !soOe)
    else $error("output enabled during pause");
  chk_oe_rise_low: assert property (@(posedge sys_clk) disable iff (!rst_n) $rose(soOe) |-> !sck)
    else $error("output enabled outside clock low phase");
  chk_so_stable_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sck && $past(sck) && soOe && $past(soOe)) |-> $stable(so))
    else $error("serial output changed while clock high");
  chk_opcode_quiet: assert property (@(posedge sck) disable iff (!rst_n || csN) s_opcode_open |-> !soOe)
    else $error("output driven during opcode");
  chk_stat_drive: assert property (@(posedge sck) disable iff (!rst_n || csN) s_stat_ready |-> soOe)
    else $error("status byte not driven after opcode");
  chk_addr_quiet: assert property (@(posedge sck) disable iff (!rst_n || csN) s_addr_open |-> !soOe)
    else $error("output driven before read address complete");
  chk_bad_opcode: assert property (@(posedge sck) disable iff (!rst_n || csN)
    (bitCnt_r >= 7'h08 && !isKnown) |-> !soOe)
    else $error("output driven after unknown opcode");
  chk_write_quiet: assert property (@(posedge sck) disable iff (!rst_n || csN)
    (bitCnt_r >= 7'h08 && isWrOp) |-> !soOe)
    else $error("output driven during write instruction");
endmodule

bind spi_eeprom_command_protect spi_eeprom_command_protect_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so), .soOe(soOe), .wpN(wpN)
);
`default_nettype wire

// ### tb/spi_eeprom_command_protect_bench.sv
// Self-checking bench for the serial EEPROM command and protection block.
`default_nettype none
module spi_eeprom_command_protect_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned WC = 200;
  logic sysClk;
  logic rstN;
  logic wpN;
  wire logic sck, csN, si, holdN, so, soOe;
  wire logic soPin;
  int failures;
  int checkCount;

  spi_eeprom_command_protect #(.WRITE_CYCLES(WC)) i_spi_eeprom_command_protect (
    .sys_clk(sysClk), .rst_n(rstN), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so), .soOe(soOe), .wpN(wpN)
  );
  spi_host_model i_spi_host_model (.sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(soPin));

  // A floating output shows the inverse of its last bit, so sampling a released pin is caught.
  assign soPin = soOe ? so : ~so;

  initial
  begin
    sysClk = 1'b0;
    forever #5 sysClk = ~sysClk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic send(input logic [7:0] bytes[$]);
    logic [7:0] rx;
    i_spi_host_model.start();
    foreach (bytes[k])
      i_spi_host_model.xbyte(bytes[k], rx);
    i_spi_host_model.stop();
  endtask

  task automatic stat(input logic [7:0] exp, input bit doPause);
    logic [7:0] rx;
    i_spi_host_model.start();
    i_spi_host_model.xbyte(8'h05, rx);
    if (doPause)
      i_spi_host_model.pause();
    i_spi_host_model.xbyte(8'h00, rx);
    i_spi_host_model.stop();
    check("status", rx, exp);
  endtask

  task automatic rd2(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] rx;
    i_spi_host_model.start();
    i_spi_host_model.xbyte(op, rx);
    i_spi_host_model.xbyte(addr[15:8], rx);
    i_spi_host_model.xbyte(addr[7:0], rx);
    i_spi_host_model.xbyte(8'h00, rx);
    check("read byte 0", rx, e0);
    i_spi_host_model.xbyte(8'h00, rx);
    check("read byte 1", rx, e1);
    i_spi_host_model.stop();
  endtask

  // The write cycle length is fixed by the parameter plus the select synchroniser.
  task automatic wait_wc();
    repeat (WC + 20) @(posedge sysClk);
  endtask

  initial
  begin
    #400000;
    failures++;
    finish_test();
  end

  initial
  begin
    rstN = 1'b0;
    wpN = 1'b1;
    failures = 0;
    checkCount = 0;
    repeat (5) @(posedge sysClk);
    rstN <= 1'b1;
    repeat (3) @(posedge sysClk);
    stat(8'h00, 1'b1);
    send('{8'h0E});
    stat(8'h02, 1'b0);
    send('{8'h0C});
    stat(8'h00, 1'b0);
    send('{8'h02, 8'h00, 8'h1E, 8'hA1});
    wait_wc();
    rd2(8'h03, 16'h001E, 8'hFF, 8'hFF);
    send('{8'h06});
    send('{8'h0A, 8'hFC, 8'h1E, 8'hA1, 8'hA2, 8'hA3});
    stat(8'hFF, 1'b0);
    send('{8'h06});
    wait_wc();
    stat(8'h00, 1'b0);
    rd2(8'h0B, 16'h001E, 8'hA1, 8'hA2);
    rd2(8'h03, 16'h0000, 8'hA3, 8'hFF);
    rd2(8'h03, 16'h03FF, 8'hFF, 8'hA3);
    send('{8'h06});
    send('{8'h09, 8'h04});
    wait_wc();
    stat(8'h04, 1'b0);
    send('{8'h06});
    send('{8'h02, 8'h02, 8'hFF, 8'h66});
    wait_wc();
    send('{8'h06});
    send('{8'h02, 8'h03, 8'h00, 8'h55});
    wait_wc();
    rd2(8'h03, 16'h02FF, 8'h66, 8'hFF);
    send('{8'h06});
    send('{8'h01, 8'h84});
    wait_wc();
    stat(8'h84, 1'b0);
    wpN <= 1'b0;
    repeat (4) @(posedge sysClk);
    send('{8'h06});
    send('{8'h01, 8'h00});
    wait_wc();
    send('{8'h04});
    stat(8'h84, 1'b0);
    send('{8'h06});
    send('{8'h02, 8'h00, 8'h40, 8'h5A});
    wait_wc();
    rd2(8'h03, 16'h0040, 8'h5A, 8'hFF);
    wpN <= 1'b1;
    repeat (4) @(posedge sysClk);
    send('{8'h06});
    send('{8'h01, 8'h00});
    wait_wc();
    stat(8'h00, 1'b0);
    send('{8'hFF, 8'h05});
    stat(8'h00, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
